// >>> logic/scsf_status.sv
// smart card serial status flags with axi4-lite register slave
//
// Notes on behaviour
// - parity error sets parity fault flag
// - bad-parity byte stored, rx full unset
// - parity fault blocks reception, sync transmit
// - parity fault clears by 0 after read-1
// - clearing rx allow keeps parity fault
// - transmit_end_flag resets 1, read-only, tx off sets while ers is 0
// - transmit_end_flag set after interval if ok, empty
// - interval 12.5, 11.5 or 11.0 etu
// - transmit_end_flag clears on tx_empty_flag clear or dma load
// - mpb reads 0, unused in smart card
// - flags accept only written zero
// - controller clears only transfer_disable_select 0, count nonzero
// - timing counted in half etu
// - error signal low sample sets ers
// - smart card meaning only with select 1
`timescale 1ns/1ns
module scsf_status
   import scsf_pkg::*;
(
   input wire logic sys_clk_i, // 125 mhz clock
   input wire logic nrst_i, // async reset, low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic rx_done_i, // pulse: character received
   input wire logic [7:0] rx_char_i, // received character
   input wire logic rx_parity_bad_i, // parity failed, with rx_done_i
   input wire logic err_sample_i, // pulse: error signal window sampled
   input wire logic err_line_i, // data line level at that sample
   input wire logic tx_start_i, // pulse: start bit of a character sent
   input wire logic dtc_tx_load_i, // pulse: controller loads tx data
   input wire logic [15:0] dtc_count_i, // controller transfer counter
   output logic [7:0] tx_char_o, // tx data register contents
   output logic tx_load_o, // pulse: tx data taken by shifter
   output logic rx_enable_o, // reception may continue
   output logic tx_enable_o, // transmission may continue
   output logic irq_o // level interrupt
);
   import scsf_pkg::*;

   logic [7:0] status_ff; // bits 7 6 4 3 2 0 stored, 1 and 5 forced 0
   logic [7:0] ctrl_ff;
   logic [7:0] rxdata_ff;
   logic [7:0] txdata_ff;
   logic [3:0] irq_stat_ff;
   logic [3:0] irq_mask_ff;
   logic [15:0] etu_ff;
   logic [7:0] seen_one_ff; // flags read as 1 since last clear
   scsf_tx_state_t tx_st_ff;
   logic aw_ff, w_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic transmit_end_flag_done;

   // write channel capture, either order
   wire aw_take = s_axi_awvalid && !aw_ff && !s_axi_bvalid;
   wire w_take = s_axi_wvalid && !w_ff && !s_axi_bvalid;
   wire wr_go = aw_ff && w_ff && !s_axi_bvalid;
   wire wr_hit = (awaddr_ff == OFS_STATUS) || (awaddr_ff == OFS_CTRL) ||
      (awaddr_ff == OFS_TXDATA) || (awaddr_ff == OFS_IRQ_STAT) ||
      (awaddr_ff == OFS_IRQ_MASK) || (awaddr_ff == OFS_ETU) || (awaddr_ff == OFS_RXDATA);
   wire wr_b0 = wr_go && wstrb_ff[0];
   wire wr_stat = wr_b0 && awaddr_ff == OFS_STATUS;
   wire wr_ctrl = wr_b0 && awaddr_ff == OFS_CTRL;
   wire wr_tx = wr_b0 && awaddr_ff == OFS_TXDATA;
   wire wr_istat = wr_b0 && awaddr_ff == OFS_IRQ_STAT;
   wire wr_imask = wr_b0 && awaddr_ff == OFS_IRQ_MASK;
   wire wr_etu = wr_go && awaddr_ff == OFS_ETU;
   assign s_axi_awready = !aw_ff && !s_axi_bvalid;
   assign s_axi_wready = !w_ff && !s_axi_bvalid;

   // read channel decode
   wire rd_go = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire rd_stat = rd_go && s_axi_araddr == OFS_STATUS;
   wire [7:0] status_view = {status_ff[7:2], 1'b0, status_ff[0]};

   // mode views
   wire smartcard_select = ctrl_ff[CTL_SMARTCARD_SELECT];
   wire re_bit = ctrl_ff[CTL_RE];
   wire te_bit = ctrl_ff[CTL_TE];
   wire parity_fault_flag = status_ff[BIT_PER];
   wire error_signal_status = status_ff[BIT_ERS];
   wire tx_empty_flag = status_ff[BIT_TX_EMPTY_FLAG];

   // processor clear: write 0 to a bit previously read as 1
   wire [7:0] cpu_clr = {8{wr_stat}} & ~wdata_ff[7:0] & seen_one_ff;
   // controller clear requires disable-select 0 and count nonzero
   wire dtc_ok = dtc_tx_load_i && !ctrl_ff[CTL_TRANSFER_DISABLE_SELECT] && (dtc_count_i != 16'h0000);

   // set events
   wire rx_ok = rx_done_i && re_bit && !parity_fault_flag;
   wire set_per = rx_ok && rx_parity_bad_i;
   wire set_rx_full_flag = rx_ok && !rx_parity_bad_i;
   wire set_ers = smartcard_select && err_sample_i && !err_line_i;
   // transmit_end_flag is timed only in smart card mode; otherwise plain tx-empty with the shifter idle
   wire transmit_end_flag_tx_off = !te_bit && !error_signal_status;
   wire transmit_end_flag_timed = smartcard_select && transmit_end_flag_done && !error_signal_status && tx_empty_flag;
   wire set_transmit_end_flag = transmit_end_flag_tx_off || transmit_end_flag_timed || (!smartcard_select && tx_empty_flag && tx_st_ff == SCSF_IDLE);
   wire clr_tx_empty_flag = cpu_clr[BIT_TX_EMPTY_FLAG] || dtc_ok;
   wire tx_take = tx_st_ff == SCSF_IDLE && !tx_empty_flag && te_bit && tx_enable_o;

   // interval target selection
   wire [5:0] transmit_end_flag_target = ctrl_ff[CTL_GM] ? 6'(TRANSMIT_END_FLAG_HALF_GM1) :
      ctrl_ff[CTL_BLK] ? 6'(TRANSMIT_END_FLAG_HALF_GM0_BLK1) : 6'(TRANSMIT_END_FLAG_HALF_GM0_BLK0);

   // parity fault halts reception and, in sync mode, transmission
   assign rx_enable_o = re_bit && !parity_fault_flag;
   assign tx_enable_o = te_bit && !(parity_fault_flag && ctrl_ff[CTL_CSYNC]);
   assign tx_char_o = txdata_ff;
   assign irq_o = |(irq_stat_ff & irq_mask_ff);

   // interval measured from each start bit
   scsf_etu_timer #(
      .CW(6)
   ) u_timer (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .half_etu_i(etu_ff),
      .start_i(tx_start_i),
      .target_i(transmit_end_flag_target),
      .done_o(transmit_end_flag_done)
   );

   // axi write address/data hold and response
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_ff <= 1'b1;
            awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (w_take)
         begin
            w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // axi read answer, one cycle after address
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= AXI_OKAY;
         case (s_axi_araddr[7:2])
            OFS_STATUS[7:2]: s_axi_rdata <= {24'h000000, status_view};
            OFS_CTRL[7:2]: s_axi_rdata <= {24'h000000, ctrl_ff};
            OFS_RXDATA[7:2]: s_axi_rdata <= {24'h000000, rxdata_ff};
            OFS_TXDATA[7:2]: s_axi_rdata <= {24'h000000, txdata_ff};
            OFS_IRQ_STAT[7:2]: s_axi_rdata <= {28'h0000000, irq_stat_ff};
            OFS_IRQ_MASK[7:2]: s_axi_rdata <= {28'h0000000, irq_mask_ff};
            OFS_ETU[7:2]: s_axi_rdata <= {16'h0000, etu_ff};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= AXI_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // read-as-one memory for clear-after-read; new read refreshes it
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         seen_one_ff <= 8'h00;
      else if (rd_stat)
         seen_one_ff <= status_view & 8'hD8;
      else
         seen_one_ff <= seen_one_ff & ~cpu_clr;
   end

   // control and configuration registers; clearing rx allow leaves flags set, rx allow 0 stops per and rx_full_flag setting
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctrl_ff <= CTRL_RST;
         irq_mask_ff <= 4'h0;
         etu_ff <= ETU_RST;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_ff <= wdata_ff[7:0];
         if (wr_imask)
            irq_mask_ff <= wdata_ff[3:0];
         if (wr_etu)
            etu_ff <= (wdata_ff[15:0] == 16'h0000) ? 16'h0001 : wdata_ff[15:0];
      end
   end

   // status flags; a set in the same cycle beats a clear
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         status_ff <= STATUS_RST;
      else
      begin
         status_ff[BIT_PER] <= set_per || (parity_fault_flag && !cpu_clr[BIT_PER]);
         status_ff[BIT_RX_FULL_FLAG] <= set_rx_full_flag || (status_ff[BIT_RX_FULL_FLAG] && !cpu_clr[BIT_RX_FULL_FLAG]);
         status_ff[BIT_ERS] <= set_ers || (error_signal_status && !cpu_clr[BIT_ERS]);
         status_ff[BIT_TX_EMPTY_FLAG] <= tx_take || (tx_empty_flag && !clr_tx_empty_flag && !wr_tx);
         status_ff[BIT_TRANSMIT_END_FLAG] <= set_transmit_end_flag || (status_ff[BIT_TRANSMIT_END_FLAG] && !clr_tx_empty_flag && !wr_tx);
         status_ff[BIT_MPB] <= 1'b0;
         status_ff[5] <= 1'b0;
         if (wr_stat)
            status_ff[BIT_MULTIPROC_BIT_TX] <= wdata_ff[BIT_MULTIPROC_BIT_TX];
      end
   end

   // received character lands in data register even on bad parity
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rxdata_ff <= 8'h00;
      else if (rx_ok)
         rxdata_ff <= rx_char_i;
   end

   // tx data register, written by cpu; a controller load keeps its value
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         txdata_ff <= 8'h00;
      else if (wr_tx)
         txdata_ff <= wdata_ff[7:0];
      else if (dtc_tx_load_i)
         txdata_ff <= 8'h00 | txdata_ff;
   end

   // simple hand-off of tx data to the shifter
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tx_st_ff <= SCSF_IDLE;
         tx_load_o <= 1'b0;
      end
      else
      begin
         tx_load_o <= tx_take;
         case (tx_st_ff)
            SCSF_IDLE:
               if (tx_take)
                  tx_st_ff <= SCSF_RUN;
            SCSF_RUN:
               if (tx_start_i)
               begin
                  tx_st_ff <= SCSF_WAIT;
               end
            SCSF_WAIT:
               if (transmit_end_flag_done || !te_bit)
               begin
                  tx_st_ff <= SCSF_IDLE;
               end
            default:
               tx_st_ff <= SCSF_IDLE;
         endcase
      end
   end

   // sticky events: per, ers, rx_full_flag sets and timed transmit_end_flag set; write 1 clears, set wins
   wire [3:0] ev = {transmit_end_flag_timed, set_rx_full_flag, set_ers, set_per};
   wire [3:0] ic = {4{wr_istat}} & wdata_ff[3:0];
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         irq_stat_ff <= 4'h0;
      else
         irq_stat_ff <= ev | (irq_stat_ff & ~ic);
   end
endmodule

// >>> inc/scsf_pkg.sv
// constants and types for the smart card serial status flag block
package scsf_pkg;
   // register byte offsets on the axi4-lite slave
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_RXDATA = 8'h08;
   localparam logic [7:0] OFS_TXDATA = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_ETU = 8'h18;
   // status bit positions
   localparam int BIT_MULTIPROC_BIT_TX = 0;
   localparam int BIT_MPB = 1;
   localparam int BIT_TRANSMIT_END_FLAG = 2;
   localparam int BIT_PER = 3;
   localparam int BIT_ERS = 4;
   localparam int BIT_RX_FULL_FLAG = 6;
   localparam int BIT_TX_EMPTY_FLAG = 7;
   // control bit positions
   localparam int CTL_RE = 0;
   localparam int CTL_TE = 1;
   localparam int CTL_GM = 2;
   localparam int CTL_BLK = 3;
   localparam int CTL_SMARTCARD_SELECT = 4;
   localparam int CTL_CSYNC = 5;
   localparam int CTL_TRANSFER_DISABLE_SELECT = 6;
   // reset values
   localparam logic [7:0] STATUS_RST = 8'h84;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] ETU_RST = 16'h0010;
   // transmit_end_flag set points in half etu, counted from start bit
   localparam int TRANSMIT_END_FLAG_HALF_GM0_BLK0 = 25; // 12.5 etu
   localparam int TRANSMIT_END_FLAG_HALF_GM0_BLK1 = 23; // 11.5 etu
   localparam int TRANSMIT_END_FLAG_HALF_GM1 = 22; // 11.0 etu
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      SCSF_IDLE = 2'b00,
      SCSF_RUN = 2'b01,
      SCSF_WAIT = 2'b10
   } scsf_tx_state_t;
endpackage

// >>> logic/scsf_etu_timer.sv
// half-etu tick generator and transmit end interval counter
`timescale 1ns/1ns
module scsf_etu_timer
   import scsf_pkg::*;
#(
   parameter int CW = 6
)
(
   input wire logic sys_clk_i, // 125 mhz clock
   input wire logic nrst_i, // async reset, low
   input wire logic [15:0] half_etu_i, // clocks per half etu
   input wire logic start_i, // start bit sent, restart count
   input wire logic [CW-1:0] target_i, // half etu count to reach
   output logic done_o // pulse when target reached
);
   logic [15:0] div_ff;
   logic [CW-1:0] cnt_ff;
   logic run_ff;
   wire tick = (div_ff >= half_etu_i - 16'h0001);
   wire hit = run_ff && tick && (cnt_ff + CW'(1) == target_i);
   // bit-rate divider, realigned to the start bit
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         div_ff <= 16'h0000;
      else if (start_i || tick)
         div_ff <= 16'h0000;
      else
         div_ff <= div_ff + 16'h0001;
   end
   // interval counter in half etu
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= hit;
         if (start_i)
         begin
            cnt_ff <= '0;
            run_ff <= 1'b1;
         end
         else if (hit)
            run_ff <= 1'b0;
         else if (run_ff && tick)
            cnt_ff <= cnt_ff + CW'(1);
      end
   end
endmodule

// >>> verification/scsf_status_checker.sv
// port assertions for the smart card status flag block
`timescale 1ns/1ns
module scsf_status_checker
   import scsf_pkg::*;
(
   input wire logic sys_clk_i, // clock
   input wire logic nrst_i, // async reset, low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic [1:0] s_axi_bresp, // write response
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic rx_done_i, // character received
   input wire logic rx_parity_bad_i, // parity failed
   input wire logic rx_enable_o, // reception may go on
   input wire logic tx_enable_o // transmission may go on
);
   logic [7:0] aw_ff;
   logic [7:0] ar_ff;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire bad_rx = rx_done_i && rx_parity_bad_i;
   // last taken addresses, so each answer can be judged by its cause
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         aw_ff <= 8'h00;
         ar_ff <= 8'h00;
      end
      else
      begin
         aw_ff <= aw_take ? s_axi_awaddr : aw_ff;
         ar_ff <= ar_take ? s_axi_araddr : ar_ff;
      end
   end
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   property p_rx_block;
      bad_rx |=> !rx_enable_o;
   endproperty
   a_rx_block: assert property (p_rx_block) else $error("rx kept open after parity fault");
   // the flag only goes by a register write, so a write answer is near
   property p_rx_reopen;
      $rose(rx_enable_o) |-> ##[0:2] s_axi_bvalid;
   endproperty
   a_rx_reopen: assert property (p_rx_reopen) else $error("rx reopened without a write");
   property p_rx_drop;
      $fell(rx_enable_o) |-> $past(bad_rx) or (##[0:2] s_axi_bvalid);
   endproperty
   a_rx_drop: assert property (p_rx_drop) else $error("rx closed without cause");
   property p_tx_reopen;
      $rose(tx_enable_o) |-> ##[0:2] s_axi_bvalid;
   endproperty
   a_tx_reopen: assert property (p_tx_reopen) else $error("tx reopened without a write");
   property p_mpb;
      s_axi_rvalid && ar_ff == OFS_STATUS |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[1];
   endproperty
   a_mpb: assert property (p_mpb) else $error("status read shows unused bits set");
   property p_slverr;
      s_axi_bvalid && aw_ff > OFS_ETU |-> s_axi_bresp == AXI_SLVERR;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
   property p_bone;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_bone: assert property (p_bone) else $error("write answered twice");
   property p_rone;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_rone: assert property (p_rone) else $error("read answered twice");
endmodule
bind scsf_status scsf_status_checker u_chk (.sys_clk_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_done_i, .rx_parity_bad_i,
   .rx_enable_o, .tx_enable_o);

// >>> verification/scsf_card_model.sv
// behavioural smart card at the far end of the serial line
`timescale 1ns/1ns
module scsf_card_model
#(
   parameter int LAT = 3, // reaction time in clocks
   parameter int ERR_AT = 60 // clocks from start bit to error window
)
(
   input wire logic sys_clk_i, // clock
   input wire logic send_i, // bench asks for one character
   input wire logic [7:0] char_i, // character to send
   input wire logic bad_i, // send it with wrong parity
   input wire logic nak_i, // answer next tx with error signal
   input wire logic tx_load_i, // device shifter took tx data
   output logic rx_done_o = 1'h0, // character complete
   output logic [7:0] rx_char_o = 8'h00, // character
   output logic rx_bad_o = 1'h0, // parity failed
   output logic err_sample_o = 1'h0, // error window sampled
   output logic err_line_o = 1'h1, // line level, pulled up
   output logic tx_start_o = 1'h0 // start bit on the line
);
   // character towards the device; released data is inverted, never stale
   always @(posedge sys_clk_i)
   begin
      if (send_i)
      begin
         repeat (LAT) @(posedge sys_clk_i);
         rx_char_o <= char_i;
         rx_bad_o <= bad_i;
         rx_done_o <= 1'h1;
         @(posedge sys_clk_i);
         rx_done_o <= 1'h0;
         rx_char_o <= ~char_i;
         rx_bad_o <= ~bad_i;
      end
   end
   // one character out, then the card answers in its error window
   always @(posedge sys_clk_i)
   begin
      if (tx_load_i)
      begin
         repeat (LAT) @(posedge sys_clk_i);
         tx_start_o <= 1'h1;
         @(posedge sys_clk_i);
         tx_start_o <= 1'h0;
         repeat (ERR_AT) @(posedge sys_clk_i);
         err_sample_o <= 1'h1;
         err_line_o <= !nak_i;
         @(posedge sys_clk_i);
         err_sample_o <= 1'h0;
         err_line_o <= 1'h1;
      end
   end
endmodule

// >>> verification/tb.sv
// self-checking bench for the smart card status flag block
`timescale 1ns/1ns
module tb;
   import scsf_pkg::*;
   logic sys_clk_i = 1'h0;
   logic nrst_i = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_char_o, rx_char_i, chr = 8'h00;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, dtc_tx_load_i = 1'h0;
   logic send = 1'h0, bad = 1'h0, nak = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [15:0] dtc_count_i = 16'h0000;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_load_o;
   logic rx_enable_o, tx_enable_o, irq_o, rx_done_i, rx_parity_bad_i, err_sample_i;
   logic err_line_i, tx_start_i;
   int errors = 0, n_tests = 0, cyc, n_load = 0;
   longint t0 = 0;
   initial forever #4 sys_clk_i = ~sys_clk_i;
   scsf_status u_dut (.sys_clk_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_done_i, .rx_char_i, .rx_parity_bad_i,
      .err_sample_i, .err_line_i, .tx_start_i, .dtc_tx_load_i, .dtc_count_i, .tx_char_o,
      .tx_load_o, .rx_enable_o, .tx_enable_o, .irq_o);
   scsf_card_model u_card (.sys_clk_i, .send_i(send), .char_i(chr), .bad_i(bad), .nak_i(nak),
      .tx_load_i(tx_load_o), .rx_done_o(rx_done_i), .rx_char_o(rx_char_i),
      .rx_bad_o(rx_parity_bad_i), .err_sample_o(err_sample_i), .err_line_o(err_line_i),
      .tx_start_o(tx_start_i));
   // start bit edge, for timing the transmit end flag
   always @(posedge sys_clk_i) if (tx_start_i === 1'b1) t0 = $time;
   // shifter hand-offs, judged at the end of the run
   always @(posedge sys_clk_i) if (tx_load_o === 1'b1) n_load++;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d, comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic pa = 1'b1;
      logic pw = 1'b1;
      @(posedge sys_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (pa || pw)
      begin
         @(negedge sys_clk_i);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         @(posedge sys_clk_i);
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      do @(negedge sys_clk_i); while (s_axi_bvalid !== 1'b1);
      rd_r = s_axi_bresp;
      @(posedge sys_clk_i);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(negedge sys_clk_i); while (s_axi_arready !== 1'b1);
      @(posedge sys_clk_i);
      s_axi_arvalid <= 1'h0;
      do @(negedge sys_clk_i); while (s_axi_rvalid !== 1'b1);
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge sys_clk_i);
      s_axi_rready <= 1'h0;
   endtask
   task automatic transfer_controller(input logic [15:0] v);
      @(posedge sys_clk_i);
      dtc_count_i <= v;
      dtc_tx_load_i <= 1'h1;
      @(posedge sys_clk_i);
      dtc_tx_load_i <= 1'h0;
   endtask
   task automatic t_reset;
      rd(OFS_STATUS);
      chk(rd_d, {24'h0, STATUS_RST});
      rd(8'h40);
      chk(rd_r, AXI_SLVERR);
      wr(8'h40, 32'h0);
      chk(rd_r, AXI_SLVERR);
      wr(OFS_ETU, 32'h4);
   endtask
   // bad parity: stored, not marked full, blocks until cleared after a read
   task automatic t_parity;
      wr(OFS_CTRL, 32'h11);
      @(posedge sys_clk_i);
      chr <= 8'h5A;
      bad <= 1'h1;
      send <= 1'h1;
      @(posedge sys_clk_i);
      send <= 1'h0;
      repeat (6) @(posedge sys_clk_i);
      chk(rx_enable_o, 1'b0);
      wr(OFS_STATUS, 32'hF6);
      rd(OFS_STATUS);
      chk(rd_d, 32'h8C);
      rd(OFS_RXDATA);
      chk(rd_d, 32'h5A);
      wr(OFS_STATUS, 32'hFE);
      rd(OFS_STATUS);
      chk(rd_d, 32'h8C);
      wr(OFS_CTRL, 32'h32);
      chk(tx_enable_o, 1'b0);
      rd(OFS_STATUS);
      chk(rd_d, 32'h8C);
      wr(OFS_CTRL, 32'h13);
      chk(tx_enable_o, 1'b1);
      wr(OFS_STATUS, 32'hF6);
      rd(OFS_STATUS);
      chk(rd_d, 32'h84);
      chk(rx_enable_o, 1'b1);
   endtask
   // one character out; measure the timed transmit end through the interrupt
   task automatic t_transmit_end_flag(input int h, input logic [7:0] c, input logic n);
      int k = 0;
      wr(OFS_CTRL, {24'h0, c});
      wr(OFS_IRQ_MASK, 32'h08);
      wr(OFS_IRQ_STAT, 32'h0F);
      nak <= n;
      wr(OFS_TXDATA, 32'hA5);
      chk(tx_char_o, 8'hA5);
      rd(OFS_STATUS);
      chk(rd_d[2], 1'b0);
      while (irq_o !== 1'b1 && k < 300)
      begin
         @(negedge sys_clk_i);
         k++;
      end
      cyc = int'(($time - t0 - 4) / 8);
      if (n)
      begin
         chk(irq_o, 1'b0);
         rd(OFS_STATUS);
         chk(rd_d, 32'h90);
         wr(OFS_STATUS, 32'hEE);
         wr(OFS_CTRL, 32'h10);
         rd(OFS_STATUS);
         chk(rd_d, 32'h84);
      end
      else
      begin
         chk(cyc >= h * 4 && cyc <= h * 4 + 6, 1'b1);
         wr(OFS_IRQ_STAT, 32'h08);
         chk(irq_o, 1'b0);
      end
   endtask
   task automatic t_dtc;
      wr(OFS_CTRL, 32'h52);
      transfer_controller(16'h0003);
      rd(OFS_STATUS);
      chk(rd_d[2], 1'b1);
      wr(OFS_CTRL, 32'h12);
      transfer_controller(16'h0000);
      rd(OFS_STATUS);
      chk(rd_d[2], 1'b1);
      transfer_controller(16'h0003);
      rd(OFS_STATUS);
      chk(rd_d[2], 1'b0);
      // let the timed end of that character land, then clear it by cpu
      repeat (150) @(posedge sys_clk_i);
      rd(OFS_STATUS);
      chk(rd_d[2], 1'b1);
      wr(OFS_STATUS, 32'h7A);
      rd(OFS_STATUS);
      chk(rd_d[2], 1'b0);
      chk(n_load, 7);
   endtask
   initial
   begin
      repeat (10) @(posedge sys_clk_i);
      nrst_i <= 1'h1;
      t_reset();
      t_parity();
      t_transmit_end_flag(TRANSMIT_END_FLAG_HALF_GM0_BLK0, 8'h12, 1'b1);
      t_transmit_end_flag(TRANSMIT_END_FLAG_HALF_GM0_BLK0, 8'h12, 1'b0);
      t_transmit_end_flag(TRANSMIT_END_FLAG_HALF_GM0_BLK1, 8'h1A, 1'b0);
      t_transmit_end_flag(TRANSMIT_END_FLAG_HALF_GM1, 8'h16, 1'b0);
      t_transmit_end_flag(TRANSMIT_END_FLAG_HALF_GM1, 8'h1E, 1'b0);
      t_dtc();
      tally_and_finish();
   end
   // hang guard, well past the thousand or so cycles the run needs
   initial
   begin
      #400000;
      errors++;
      tally_and_finish();
   end
endmodule
